// ### bench/irqcfg_host.sv
// Host model: pull resistors on both interrupt pins, trigger driver.
// Assumes the bench clock; trigger edges change right after a rise.
`timescale 1ns/1ns
module irqcfg_host (
   // Clock
   input wire logic i_sys_clk,
   // Pins from the device
   input wire logic i_one_o,
   input wire logic i_one_oe,
   input wire logic i_two_o,
   input wire logic i_two_oe,
   // Board setup
   input wire logic i_pull_up,
   input wire logic i_drive_en,
   // Resolved pin levels
   output logic o_one_lvl,
   output logic o_two_lvl
);
   logic drive_lvl_r = 1'b0;
   // Released pin settles to the resistor, never to a stale level
   assign o_one_lvl = i_one_oe ? i_one_o : i_pull_up;
   assign o_two_lvl = i_drive_en ? drive_lvl_r :
      (i_two_oe ? i_two_o : i_pull_up);
   // Long high and low phases so the synchroniser sees both levels
   task automatic trig_edge();
      @(posedge i_sys_clk);
      drive_lvl_r <= 1'b1;
      repeat (8) @(posedge i_sys_clk);
      drive_lvl_r <= 1'b0;
      repeat (8) @(posedge i_sys_clk);
   endtask
endmodule

// ### bench/testbench.sv
// Self-checking bench for the interrupt pin and trigger block.
// Assumes the host model beside it and a stub datapath in here.
`timescale 1ns/1ns
module testbench;
   import irqcfg_pkg::*;
   // ****************************************************************
   // Signals
   // ****************************************************************
   logic i_sys_clk = 1'b0;
   logic i_sys_rst = 1'b1;
   logic i_soft_rst = 1'b0;
   logic i_hibernate = 1'b0;
   logic [7:0] i_addr = 8'h00;
   logic [7:0] i_wr_data = 8'h00;
   logic i_wr_en = 1'b0;
   logic i_rd_en = 1'b0;
   logic [7:0] o_rd_data;
   logic i_boot_strap = 1'b0;
   logic i_acq_done = 1'b0;
   logic buf_off = 1'b1;
   logic [7:0] decim = 8'h03;
   logic [NEV-EV_EXT-1:0] i_ext_evt = 2'h0;
   logic o_irq_one_o, o_irq_one_oe, o_irq_two_o, o_irq_two_oe;
   logic o_acq_start, o_trig_mode, o_irq;
   logic pull_up = 1'b0;
   logic drive_en = 1'b0;
   logic one_lvl, two_lvl;
   logic rd_pend = 1'b0;
   logic [7:0] exp_q[$];
   logic [31:0] rnd;
   integer seed = 32'h1341;
   int n_errors = 0;
   int n_compared = 0;
   int start_cnt = 0;
   int done_wait = 0;
   int cyc = 0;
   int base, n_low, n_exp;
   initial
   begin
      forever #5 i_sys_clk = ~i_sys_clk;
   end
   irqcfg_top dut (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst),
      .i_soft_rst(i_soft_rst), .i_hibernate(i_hibernate),
      .i_addr(i_addr), .i_wr_data(i_wr_data), .i_wr_en(i_wr_en),
      .i_rd_en(i_rd_en), .o_rd_data(o_rd_data),
      .i_boot_strap(i_boot_strap), .i_irq_two_in(two_lvl),
      .o_irq_one_o(o_irq_one_o), .o_irq_one_oe(o_irq_one_oe),
      .o_irq_two_o(o_irq_two_o), .o_irq_two_oe(o_irq_two_oe),
      .i_decim(decim), .i_acq_done(i_acq_done), .i_buf_off(buf_off),
      .i_ext_evt(i_ext_evt), .o_acq_start(o_acq_start),
      .o_trig_mode(o_trig_mode), .o_irq(o_irq));
   irqcfg_host host (.i_sys_clk(i_sys_clk), .i_one_o(o_irq_one_o),
      .i_one_oe(o_irq_one_oe), .i_two_o(o_irq_two_o),
      .i_two_oe(o_irq_two_oe), .i_pull_up(pull_up),
      .i_drive_en(drive_en), .o_one_lvl(one_lvl), .o_two_lvl(two_lvl));
   // ****************************************************************
   // Checks and bus tasks
   // ****************************************************************
   task automatic stop_test();
      if (n_errors == 0 && n_compared > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic cmp_val(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         n_errors++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic cmp_pin(input logic got, input logic exp);
      n_compared++;
      if (got !== exp)
      begin
         n_errors++;
         $display("[FAIL] %0t pin got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wait_n(input int n);
      repeat (n) @(posedge i_sys_clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_sys_clk);
      i_addr <= a;
      i_wr_data <= d;
      i_wr_en <= 1'b1;
      @(posedge i_sys_clk);
      i_wr_en <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      @(posedge i_sys_clk);
      i_addr <= a;
      i_rd_en <= 1'b1;
      @(posedge i_sys_clk);
      i_rd_en <= 1'b0;
   endtask
   task automatic evt();
      @(posedge i_sys_clk);
      i_ext_evt <= 2'h3;
      @(posedge i_sys_clk);
      i_ext_evt <= 2'h0;
   endtask
   task automatic rst_pulse(input logic hib);
      @(posedge i_sys_clk);
      i_soft_rst <= ~hib;
      i_hibernate <= hib;
      @(posedge i_sys_clk);
      i_soft_rst <= 1'b0;
      i_hibernate <= 1'b0;
   endtask
   // Stub datapath: each start finishes three cycles later
   always @(posedge i_sys_clk)
   begin
      i_acq_done <= (done_wait == 1);
      if (o_acq_start === 1'b1)
      begin
         start_cnt <= start_cnt + 1;
         done_wait <= 3;
      end
      else if (done_wait > 0)
         done_wait <= done_wait - 1;
   end
   // Read data stand only in the cycle after the strobe
   always @(posedge i_sys_clk)
   begin
      if (rd_pend)
         cmp_val({8'h00, o_rd_data}, {8'h00, exp_q.pop_front()});
      rd_pend <= i_rd_en;
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         n_errors++;
         stop_test();
      end
   end
   // ****************************************************************
   // Scenarios
   // ****************************************************************
   initial
   begin
      repeat (5) @(posedge i_sys_clk);
      i_sys_rst <= 1'b0;
      wait_n(6);
      cmp_pin(o_irq_one_oe, 1'b1);
      cmp_pin(one_lvl, 1'b0);
      rd(ADDR_CFG4, CFG4_RST);
      rd(8'h55, 8'h00);
      rd(ADDR_SYS, 8'h00);
      wr(ADDR_MAP, 8'h04);
      wr(ADDR_MASK, 8'h0C);
      for (int i = 0; i < 4; i++)
      begin
         pull_up <= ~i[0];
         wr(ADDR_CFG4, 8'(i));
         evt();
         wait_n(4);
         cmp_pin(one_lvl, i[0]);
         cmp_pin(two_lvl, i[0]);
         cmp_pin(o_irq, 1'b1);
         wr(ADDR_STAT, 8'h0C);
         wait_n(4);
         cmp_pin(one_lvl, ~i[0]);
         cmp_pin(o_irq_one_oe, ~i[1]);
         cmp_pin(o_irq_two_oe, ~i[1]);
         cmp_pin(o_irq, 1'b0);
      end
      wr(ADDR_MASK, 8'h00);
      evt();
      wait_n(4);
      cmp_pin(o_irq, 1'b0);
      rd(ADDR_STAT, 8'h0C);
      wr(ADDR_STAT, 8'h0C);
      rd(ADDR_STAT, 8'h00);
      // Only driver and polarity survive a soft reset
      rnd = $random(seed);
      wr(ADDR_CFG4, {1'b1, rnd[2:0], 4'h6});
      rd(ADDR_CFG4, {1'b1, rnd[2:0], 4'h6});
      rst_pulse(1'b0);
      rd(ADDR_CFG4, 8'h02);
      rst_pulse(1'b1);
      rd(ADDR_CFG4, 8'h01);
      wr(ADDR_CFG4, 8'h85);
      wr(ADDR_MAP, 8'h0F);
      wr(ADDR_MASK, 8'h0F);
      evt();
      wait_n(4);
      cmp_pin(o_irq_two_oe, 1'b0);
      wr(ADDR_STAT, 8'h0F);
      rd(ADDR_SYS, 8'h01);
      cmp_pin(o_trig_mode, 1'b1);
      drive_en <= 1'b1;
      base = start_cnt;
      host.trig_edge();
      wait_n(40);
      cmp_val(16'(start_cnt - base), 16'h0003);
      rd(ADDR_STAT, 8'h03);
      wr(ADDR_STAT, 8'h03);
      wr(ADDR_CFG4, 8'h05);
      base = start_cnt;
      host.trig_edge();
      host.trig_edge();
      wait_n(10);
      rd(ADDR_STAT, 8'h02);
      host.trig_edge();
      wait_n(10);
      rd(ADDR_STAT, 8'h03);
      cmp_val(16'(start_cnt - base), 16'h0003);
      wr(ADDR_STAT, 8'h03);
      // Buffering on: full run, random decimation, no data ready
      buf_off <= 1'b0;
      decim <= {6'h00, rnd[5:4]};
      n_exp = (rnd[5:4] == 2'h0) ? 1 : int'(rnd[5:4]);
      wr(ADDR_CFG4, 8'h85);
      base = start_cnt;
      host.trig_edge();
      wait_n(40);
      cmp_val(16'(start_cnt - base), 16'(n_exp));
      rd(ADDR_STAT, 8'h02);
      wr(ADDR_STAT, 8'h03);
      buf_off <= 1'b1;
      decim <= 8'h03;
      wr(ADDR_MAP, 8'h00);
      wr(ADDR_MASK, 8'h01);
      wr(ADDR_CFG4, 8'h8C);
      pull_up <= 1'b1;
      // Let the new polarity reach the pin before counting
      wait_n(2);
      n_low = 0;
      fork
         host.trig_edge();
         repeat (4000) @(posedge i_sys_clk) if (one_lvl === 1'b0) n_low++;
      join
      cmp_val(16'(n_low), 16'(PULSE_CYC));
      // Strap at supply overrides every pin setting
      i_boot_strap <= 1'b1;
      drive_en <= 1'b0;
      wr(ADDR_CFG4, 8'h07);
      wr(ADDR_MAP, 8'h04);
      wr(ADDR_MASK, 8'h0C);
      wr(ADDR_STAT, 8'h0F);
      wait_n(6);
      rd(ADDR_SYS, 8'h00);
      cmp_pin(o_trig_mode, 1'b0);
      evt();
      wait_n(4);
      cmp_pin(two_lvl, 1'b0);
      cmp_pin(o_irq_two_oe, 1'b1);
      cmp_pin(one_lvl, 1'b0);
      wr(ADDR_STAT, 8'h0C);
      wait_n(4);
      cmp_pin(o_irq_two_oe, 1'b0);
      cmp_pin(two_lvl, 1'b1);
      cmp_pin(one_lvl, 1'b1);
      drive_en <= 1'b1;
      base = start_cnt;
      host.trig_edge();
      wait_n(10);
      cmp_val(16'(start_cnt - base), 16'h0000);
      wait_n(3);
      stop_test();
   end
endmodule

// ### hdl/irqcfg_pad.sv
// Interrupt pin driver: polarity, push-pull or open drive, input mode.
// Assumes the enclosing wire resolves level from pin_o and pin_oe.
`timescale 1ns/1ns
module irqcfg_pad (
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_sys_rst,
   // Pin control
   irqcfg_pad_if.drv p
);
   import irqcfg_pkg::*;
   typedef struct packed {
      logic o;
      logic oe;
   } irqcfg_pad_s;
   irqcfg_pad_s r, n;

   always_comb
   begin
      n.o = p.assert_lvl ~^ p.active_high;
      n.oe = 1'b1;
      if (p.input_mode)
         n.oe = 1'b0;
      else if (p.open_drv)
      begin
         n.o = p.active_high;
         n.oe = p.assert_lvl;
      end
   end

   always_ff @(posedge i_sys_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
         r <= '0;
      else
         r <= n;
   end

   assign p.pin_o = r.o;
   assign p.pin_oe = r.oe;

   property p_in_hiz;
      @(posedge i_sys_clk) disable iff (i_sys_rst)
      p.input_mode |=> !p.pin_oe;
   endproperty
   a_in_hiz: assert property (p_in_hiz)
      else $error("input pin driven");

   property p_od_release;
      @(posedge i_sys_clk) disable iff (i_sys_rst)
      !p.input_mode && p.open_drv
         |=> p.pin_oe == $past(p.assert_lvl)
            && (!p.pin_oe || p.pin_o == $past(p.active_high));
   endproperty
   a_od_release: assert property (p_od_release)
      else $error("open drive level wrong");

   property p_pp_level;
      @(posedge i_sys_clk) disable iff (i_sys_rst)
      !p.input_mode && !p.open_drv
         |=> p.pin_oe
            && p.pin_o == ($past(p.assert_lvl) ~^ $past(p.active_high));
   endproperty
   a_pp_level: assert property (p_pp_level)
      else $error("push-pull level wrong");
endmodule

// ### hdl/irqcfg_sync.sv
// Three-stage pin synchroniser with stable level and rise pulse.
// Assumes the pin is asynchronous to i_sys_clk.
`timescale 1ns/1ns
module irqcfg_sync (
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_sys_rst,
   // Pin and result
   input wire logic i_pin,
   output logic o_level,
   output logic o_rise
);
   import irqcfg_pkg::*;
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic lvl;
      logic rise;
   } irqcfg_sync_s;
   irqcfg_sync_s r, n;

   always_comb
   begin
      n = r;
      n.s1 = i_pin;
      n.s2 = r.s1;
      n.s3 = r.s2;
      n.rise = 1'b0;
      // Change counts once stages two and three agree
      if (r.s2 == r.s3)
      begin
         n.lvl = r.s3;
         n.rise = r.s3 & ~r.lvl;
      end
   end

   always_ff @(posedge i_sys_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
         r <= '0;
      else
         r <= n;
   end

   assign o_level = r.lvl;
   assign o_rise = r.rise;

   property p_rise_once;
      @(posedge i_sys_clk) disable iff (i_sys_rst)
      o_rise |=> !o_rise && o_level;
   endproperty
   a_rise_once: assert property (p_rise_once)
      else $error("trigger rise not single");
endmodule

// ### hdl/irqcfg_top.sv
// Interrupt pin and external trigger configuration for the sensor.
// Assumes a same-clock register port and a datapath that acknowledges
// each started acquisition with a done pulse.
//
// Our own choice: the strobed register port.
`timescale 1ns/1ns
module irqcfg_top (
   // Clock and resets
   input wire logic i_sys_clk,
   input wire logic i_sys_rst,
   input wire logic i_soft_rst,
   input wire logic i_hibernate,
   // Register port
   input wire logic [7:0] i_addr,
   input wire logic [7:0] i_wr_data,
   input wire logic i_wr_en,
   input wire logic i_rd_en,
   output logic [7:0] o_rd_data,
   // Pins
   input wire logic i_boot_strap,
   input wire logic i_irq_two_in,
   output logic o_irq_one_o,
   output logic o_irq_one_oe,
   output logic o_irq_two_o,
   output logic o_irq_two_oe,
   // Acquisition datapath
   input wire logic [7:0] i_decim,
   input wire logic i_acq_done,
   input wire logic i_buf_off,
   input wire logic [irqcfg_pkg::NEV-irqcfg_pkg::EV_EXT-1:0] i_ext_evt,
   output logic o_acq_start,
   output logic o_trig_mode,
   // Interrupt
   output logic o_irq
);
   import irqcfg_pkg::*;

   // ****************************************************************
   // State
   // ****************************************************************
   typedef struct packed {
      logic [7:0] cfg;
      logic [NEV-1:0] map;
      logic [NEV-1:0] stat;
      logic [NEV-1:0] mask;
      logic [7:0] rdata;
      logic [8:0] cnt;
      irqcfg_acq_e st;
      logic [11:0] pcnt;
      logic pulse;
      logic start;
      logic irq;
      logic [1:0] sys;
   } irqcfg_top_s;

   localparam irqcfg_top_s RST_STATE = '{
      cfg: CFG4_RST,
      map: EV_RST,
      stat: EV_RST,
      mask: EV_RST,
      rdata: 8'h00,
      cnt: 9'h000,
      st: AQ_IDLE,
      pcnt: 12'h000,
      pulse: 1'b0,
      start: 1'b0,
      irq: 1'b0,
      sys: 2'h0
   };

   irqcfg_top_s r, n;

   function automatic logic hit(input logic [7:0] a,
                                input logic [7:0] off);
      hit = (a == off);
   endfunction

   // ****************************************************************
   // Pin synchronisers
   // ****************************************************************
   logic bt_lvl;
   logic two_rise;

   irqcfg_sync u_sync_bt (
      .i_sys_clk(i_sys_clk),
      .i_sys_rst(i_sys_rst),
      .i_pin(i_boot_strap),
      .o_level(bt_lvl),
      .o_rise()
   );

   irqcfg_sync u_sync_two (
      .i_sys_clk(i_sys_clk),
      .i_sys_rst(i_sys_rst),
      .i_pin(i_irq_two_in),
      .o_level(),
      .o_rise(two_rise)
   );

   // ****************************************************************
   // Effective pin settings
   // ****************************************************************
   logic trig_en;
   logic act_high;
   logic open_drv;
   logic pulse_en;
   logic [NEV-1:0] pend;
   logic [NEV-1:0] pin_ev;

   always_comb
   begin
      trig_en = r.cfg[CFG_TPS] & ~bt_lvl;
      act_high = r.cfg[CFG_POL] & ~bt_lvl;
      open_drv = r.cfg[CFG_DRV] | bt_lvl;
      // Pulse option has no effect in strap mode
      pulse_en = r.cfg[CFG_RPE] & ~bt_lvl;
      pend = r.stat & r.mask;
      pin_ev = pend;
      // Pulse replaces the held level, still OR'd with the rest
      if (pulse_en)
         pin_ev[EV_DRDY] = r.pulse;
   end

   irqcfg_pad_if pad_one ();
   irqcfg_pad_if pad_two ();

   always_comb
   begin
      pad_one.assert_lvl = |(pin_ev & ~r.map);
      pad_one.active_high = act_high;
      pad_one.open_drv = open_drv;
      pad_one.input_mode = 1'b0;
      // Routing to pin two is dropped while it is a trigger input
      pad_two.assert_lvl = |(pin_ev & r.map) & ~trig_en;
      pad_two.active_high = act_high;
      pad_two.open_drv = open_drv;
      pad_two.input_mode = trig_en;
   end

   irqcfg_pad u_pad_one (
      .i_sys_clk(i_sys_clk),
      .i_sys_rst(i_sys_rst),
      .p(pad_one.drv)
   );

   irqcfg_pad u_pad_two (
      .i_sys_clk(i_sys_clk),
      .i_sys_rst(i_sys_rst),
      .p(pad_two.drv)
   );

   // ****************************************************************
   // Next state
   // ****************************************************************
   logic trig_ev;
   logic [8:0] dec;
   logic last;
   logic complete;
   logic [NEV-1:0] set;
   logic [NEV-1:0] clr;

   always_comb
   begin
      n = r;
      n.start = 1'b0;
      n.rdata = 8'h00;
      complete = 1'b0;
      trig_ev = trig_en & two_rise;
      // Decimation of zero behaves as one
      dec = (i_decim == 8'h00) ? 9'h001 : {1'b0, i_decim};
      last = (r.cnt + 9'h001) >= dec;

      // Register reads
      if (i_rd_en)
      begin
         if (hit(i_addr, ADDR_CFG4))
            n.rdata = r.cfg;
         else if (hit(i_addr, ADDR_MAP))
            n.rdata = {4'h0, r.map};
         else if (hit(i_addr, ADDR_STAT))
            n.rdata = {4'h0, r.stat};
         else if (hit(i_addr, ADDR_MASK))
            n.rdata = {4'h0, r.mask};
         else if (hit(i_addr, ADDR_SYS))
            n.rdata = {6'h00, r.sys};
      end

      // Register writes
      if (i_wr_en && hit(i_addr, ADDR_CFG4))
         n.cfg = i_wr_data;
      if (i_wr_en && hit(i_addr, ADDR_MAP))
         n.map = i_wr_data[NEV-1:0];
      if (i_wr_en && hit(i_addr, ADDR_MASK))
         n.mask = i_wr_data[NEV-1:0];
      clr = (i_wr_en && hit(i_addr, ADDR_STAT)) ?
         i_wr_data[NEV-1:0] : EV_RST;

      // Acquisition sequencing
      unique case (r.st)
         AQ_IDLE:
         begin
            if (trig_ev)
            begin
               n.start = 1'b1;
               n.st = AQ_WAIT;
            end
         end
         AQ_WAIT:
         begin
            if (i_acq_done)
            begin
               if (last)
               begin
                  n.cnt = 9'h000;
                  n.st = AQ_IDLE;
                  complete = 1'b1;
               end
               else
               begin
                  n.cnt = r.cnt + 9'h001;
                  // Mode 1 chains the rest without another edge
                  if (r.cfg[CFG_TAM])
                     n.start = 1'b1;
                  else
                     n.st = AQ_IDLE;
               end
            end
         end
      endcase
      // Dropping trigger mode while idle abandons a partial result
      if (!trig_en && r.st == AQ_IDLE)
         n.cnt = 9'h000;

      // Sticky events, a new event beats a same-cycle clear
      set = EV_RST;
      set[EV_DRDY] = complete & i_buf_off;
      set[EV_TRIG] = trig_ev;
      set[NEV-1:EV_EXT] = i_ext_evt;
      n.stat = (r.stat & ~clr) | set;

      // Data-ready pulse timer
      if (set[EV_DRDY] && pulse_en)
      begin
         n.pulse = 1'b1;
         n.pcnt = PULSE_LOAD;
      end
      else if (r.pulse)
      begin
         if (r.pcnt == 12'h000)
            n.pulse = 1'b0;
         else
            n.pcnt = r.pcnt - 12'h001;
      end

      n.sys[SYS_TRIG] = trig_en;
      n.sys[SYS_BUSY] = (n.st == AQ_WAIT);
      n.irq = |((r.stat & ~clr | set) & n.mask);

      // Soft reset keeps driver type and polarity
      if (i_soft_rst)
      begin
         n = RST_STATE;
         n.cfg[CFG_DRV] = r.cfg[CFG_DRV];
         n.cfg[CFG_POL] = r.cfg[CFG_POL];
      end
      if (i_hibernate)
         n = RST_STATE;
   end

   always_ff @(posedge i_sys_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
         r <= RST_STATE;
      else
         r <= n;
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   assign o_rd_data = r.rdata;
   assign o_acq_start = r.start;
   assign o_trig_mode = r.sys[SYS_TRIG];
   assign o_irq = r.irq;
   assign o_irq_one_o = pad_one.pin_o;
   assign o_irq_one_oe = pad_one.pin_oe;
   assign o_irq_two_o = pad_two.pin_o;
   assign o_irq_two_oe = pad_two.pin_oe;

   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (i_sys_rst);

   property p_strap_no_trig;
      bt_lvl |=> !o_trig_mode ##1 o_irq_two_oe == pad_two.assert_lvl
         || $past(pad_two.assert_lvl) == o_irq_two_oe;
   endproperty
   a_strap_no_trig: assert property (p_strap_no_trig)
      else $error("trigger active under strap");

   property p_out_mode;
      !trig_en && !i_soft_rst && !i_hibernate && !bt_lvl
         |=> !r.sys[SYS_TRIG];
   endproperty
   a_out_mode: assert property (p_out_mode)
      else $error("trigger shown while output");

   property p_edge_start;
      trig_ev && r.st == AQ_IDLE && !i_soft_rst && !i_hibernate
         |=> o_acq_start && r.sys[SYS_BUSY];
   endproperty
   a_edge_start: assert property (p_edge_start)
      else $error("edge did not start capture");

   property p_chain;
      r.st == AQ_WAIT && i_acq_done && !last && r.cfg[CFG_TAM]
         && !i_soft_rst && !i_hibernate |=> o_acq_start;
   endproperty
   a_chain: assert property (p_chain)
      else $error("decimated run stalled");

   property p_single;
      r.st == AQ_WAIT && i_acq_done && !r.cfg[CFG_TAM]
         |=> !o_acq_start && r.st == AQ_IDLE;
   endproperty
   a_single: assert property (p_single)
      else $error("single mode chained");

   property p_drdy_cause;
      !r.stat[EV_DRDY] ##1 r.stat[EV_DRDY]
         |-> $past(complete) && $past(i_buf_off);
   endproperty
   a_drdy_cause: assert property (p_drdy_cause)
      else $error("data ready without result");

   property p_pulse_len;
      $rose(r.pulse) |-> r.pcnt == PULSE_LOAD ##1 r.pulse[*8];
   endproperty
   a_pulse_len: assert property (p_pulse_len)
      else $error("pulse too short");

   property p_soft_keep;
      i_soft_rst && !i_hibernate
         |=> r.cfg[1:0] == $past(r.cfg[1:0]) && r.stat == EV_RST;
   endproperty
   a_soft_keep: assert property (p_soft_keep)
      else $error("pin settings lost on soft reset");

   property p_set_wins;
      i_wr_en && hit(i_addr, ADDR_STAT) && i_wr_data[EV_TRIG] && trig_ev
         && !i_soft_rst && !i_hibernate |=> r.stat[EV_TRIG];
   endproperty
   a_set_wins: assert property (p_set_wins)
      else $error("event lost to clear");

   property p_strap_od;
      // Pad is registered, so the first strap cycle still shows old drive
      bt_lvl && $past(bt_lvl) && o_irq_one_oe |-> !o_irq_one_o;
   endproperty
   a_strap_od: assert property (p_strap_od)
      else $error("strap pin not open-drain low");
endmodule

// ### include/irqcfg_pad_if.sv
// Carrier between the control logic and one interrupt pin driver.
// Assumes both ends share the system clock.
`timescale 1ns/1ns
interface irqcfg_pad_if;
   logic assert_lvl;
   logic active_high;
   logic open_drv;
   logic input_mode;
   logic pin_o;
   logic pin_oe;
   modport ctl (
      output assert_lvl, active_high, open_drv, input_mode,
      input pin_o, pin_oe
   );
   modport drv (
      input assert_lvl, active_high, open_drv, input_mode,
      output pin_o, pin_oe
   );
endinterface

// ### include/irqcfg_pkg.sv
// Constants for the interrupt pin and trigger configuration block.
// Assumes one 100 MHz clock and an 8-bit register port.
package irqcfg_pkg;
   // ****************************************************************
   // Register offsets
   // ****************************************************************
   localparam logic [7:0] ADDR_CFG4 = 8'h18;
   localparam logic [7:0] ADDR_MAP = 8'h20;
   localparam logic [7:0] ADDR_STAT = 8'h21;
   localparam logic [7:0] ADDR_MASK = 8'h22;
   localparam logic [7:0] ADDR_SYS = 8'h23;
   // ****************************************************************
   // Field positions and reset values
   // ****************************************************************
   localparam int CFG_POL = 0;
   localparam int CFG_DRV = 1;
   localparam int CFG_TPS = 2;
   localparam int CFG_RPE = 3;
   localparam int CFG_TAM = 7;
   localparam logic [7:0] CFG4_RST = 8'h01;
   localparam int NEV = 4;
   localparam int EV_DRDY = 0;
   localparam int EV_TRIG = 1;
   localparam int EV_EXT = 2;
   localparam logic [NEV-1:0] EV_RST = 4'h0;
   localparam int SYS_TRIG = 0;
   localparam int SYS_BUSY = 1;
   // ****************************************************************
   // Timing
   // ****************************************************************
   localparam int CLK_MHZ = 100;
   localparam int PULSE_US = 32;
   localparam int PULSE_CYC = PULSE_US * CLK_MHZ;
   localparam logic [11:0] PULSE_LOAD = 12'(PULSE_CYC - 1);
   typedef enum logic {AQ_IDLE, AQ_WAIT} irqcfg_acq_e;
endpackage
